// File: rtl/ewt_pkg.sv
// Package: register map, field layout and mode codes of the waveform timer
package ewt_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] EWT_CTRL_OFS    = 8'hb0;
  localparam logic [7:0] EWT_COUNT_OFS   = 8'hb4;
  localparam logic [7:0] EWT_COMPARE_OFS = 8'hb8;
  localparam logic [7:0] EWT_FLAGS_OFS   = 8'hbc;
  localparam logic [7:0] EWT_PORT_OFS    = 8'hc0;

  // Control field positions
  localparam int EWT_FOC_BIT  = 7;
  localparam int EWT_WGM0_BIT = 6;
  localparam int EWT_COM_HI   = 5;
  localparam int EWT_COM_LO   = 4;
  localparam int EWT_WGM1_BIT = 3;
  localparam int EWT_CS_HI    = 2;
  localparam int EWT_CS_LO    = 0;

  // Flag and port bit positions
  localparam int EWT_OVF_BIT = 0;
  localparam int EWT_CMF_BIT = 1;
  localparam int EWT_DIR_BIT = 0;

  // Reset values
  localparam logic [7:0] EWT_CTRL_RST  = 8'h00;
  localparam logic [7:0] EWT_COUNT_RST = 8'h00;
  localparam logic [7:0] EWT_CMP_RST   = 8'h00;

  // Counter limits
  localparam logic [7:0] EWT_BOTTOM = 8'h00;
  localparam logic [7:0] EWT_MAX    = 8'hff;

  // Read answer for unmapped offsets
  localparam logic [31:0] EWT_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {
    EWT_NORMAL   = 2'h0,
    EWT_PHASE    = 2'h1,
    EWT_CTC      = 2'h2,
    EWT_FAST     = 2'h3
  } ewt_mode_t;

  typedef struct packed {
    logic [1:0] com;
    ewt_mode_t  mode;
    logic [2:0] cs;
  } ewt_ctrl_t;

  typedef struct packed {
    logic       match;
    logic       up;
    logic       at_top;
    logic       at_bottom;
  } ewt_evt_t;

endpackage

// File: rtl/ewt_prescaler.sv
// Prescaler producing a one-cycle timer tick per clock select
`timescale 1ns/1ps
module ewt_prescaler import ewt_pkg::*; (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Selection and tick
  input  wire logic [2:0] cs,
  output logic            tick
);

  logic [9:0] div_reg;
  logic [9:0] div_next;

  function automatic logic tap_hit(input logic [2:0] sel,
                                   input logic [9:0] d);
    case (sel)
      3'h1:    tap_hit = 1'b1;
      3'h2:    tap_hit = (d[2:0] == 3'h7);
      3'h3:    tap_hit = (d[4:0] == 5'h1f);
      3'h4:    tap_hit = (d[5:0] == 6'h3f);
      3'h5:    tap_hit = (d[6:0] == 7'h7f);
      3'h6:    tap_hit = (d[7:0] == 8'hff);
      3'h7:    tap_hit = (d == 10'h3ff);
      default: tap_hit = 1'b0;
    endcase
  endfunction

  always_comb begin
    div_next = div_reg + 10'h001;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= 10'h000;
    end else begin
      div_reg <= div_next;
    end
  end

  assign tick = tap_hit(cs, div_reg);

endmodule

// File: rtl/ewt_waveform.sv
// Waveform generator for the single compare output
`timescale 1ns/1ps
module ewt_waveform import ewt_pkg::*; (
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      resetn,
  // Control and events
  input  wire ewt_ctrl_t ctrl,
  input  wire logic      tick,
  input  wire ewt_evt_t  evt,
  input  wire logic      force_cmp,
  input  wire logic      cmp_is_max,
  input  wire logic      sym_fix,
  // Output
  output logic           wave
);

  logic wave_reg;
  logic wave_next;

  always_comb begin
    wave_next = wave_reg;
    case (ctrl.mode)
      EWT_NORMAL, EWT_CTC: begin
        if ((tick && evt.match) || force_cmp) begin
          case (ctrl.com)
            2'h1:    wave_next = ~wave_reg;
            2'h2:    wave_next = 1'b0;
            2'h3:    wave_next = 1'b1;
            default: wave_next = wave_reg;
          endcase
        end
      end
      EWT_FAST: begin
        // Fast PWM; toggle code; match at TOP ignored
        // Wrap from MAX is the BOTTOM edge, so compare 0 still spikes
        if (tick) begin
          if (ctrl.com == 2'h1 && evt.match) begin
            wave_next = ~wave_reg;
          end else if (ctrl.com[1] && evt.match && !cmp_is_max) begin
            wave_next = ctrl.com[0];
          end else if (ctrl.com[1] && evt.at_top) begin
            wave_next = ~ctrl.com[0];
          end
        end
      end
      EWT_PHASE: begin
        // Up match clears/sets, down match the opposite
        // Compare at TOP acts at TOP; extremes; symmetry
        if (tick && ctrl.com[1]) begin
          if (cmp_is_max && evt.at_top) begin
            wave_next = ~ctrl.com[0];
          end else if (sym_fix) begin
            wave_next = ctrl.com[0];
          end else if (evt.match && !cmp_is_max) begin
            // Turning at BOTTOM: a match there counts as up-counting
            wave_next = (evt.up || evt.at_bottom) ? ctrl.com[0] : ~ctrl.com[0];
          end
        end
      end
      default: wave_next = wave_reg;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wave_reg <= 1'b0;
    end else begin
      wave_reg <= wave_next;
    end
  end

  assign wave = wave_reg;

endmodule

// File: rtl/ewt_timer.sv
// Top of the eight-bit waveform timer with its Avalon-MM slave
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
module ewt_timer import ewt_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Waveform pin
  output logic             waveform_output,
  output logic             waveform_output_oe_n,
  output logic             port_override,
  // Flags as levels
  output logic             overflow_flag,
  output logic             compare_match_flag
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_reg,   ctrl_next;
  logic [7:0]  count_reg,  count_next;
  logic [7:0]  cmp_buf_reg, cmp_buf_next;
  logic [7:0]  cmp_reg,    cmp_next;
  logic        down_reg,   down_next;
  logic        ovf_reg,    ovf_next;
  logic        cmf_reg,    cmf_next;
  logic        dir_reg,    dir_next;
  logic        block_reg,  block_next;
  logic        ack_reg,    ack_next;
  logic [31:0] rdata_reg,  rdata_next;

  ewt_ctrl_t ctrl;
  ewt_evt_t  evt;
  logic      tick;
  logic      wave;
  logic      req;
  logic      wr_take;
  logic      force_cmp;
  logic      sym_fix;
  logic      sym_leave;
  logic      sym_missed;
  logic      ovf_set;
  logic      cmf_set;
  logic      cmp_is_max;
  logic [7:0] top_val;
  logic      pwm_mode;

  // Mode from bits 6 and 3
  assign ctrl.mode = ewt_mode_t'({ctrl_reg[EWT_WGM1_BIT],
                                  ctrl_reg[EWT_WGM0_BIT]});
  assign ctrl.com  = ctrl_reg[EWT_COM_HI:EWT_COM_LO];
  assign ctrl.cs   = ctrl_reg[EWT_CS_HI:EWT_CS_LO];
  assign pwm_mode  = (ctrl.mode == EWT_PHASE) || (ctrl.mode == EWT_FAST);
  assign top_val   = (ctrl.mode == EWT_CTC) ? cmp_reg : EWT_MAX;
  assign cmp_is_max = (cmp_reg == EWT_MAX);

  // ----------------------------------------------------------------
  // Bus slave: one wait state, answer on the second edge
  // ----------------------------------------------------------------
  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_reg;
  assign wr_take         = avs_write && ack_reg;

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [31:0] wd,
                                       input logic [3:0] be);
    merge = be[0] ? wd[7:0] : old;
  endfunction

  always_comb begin
    ack_next   = req && !ack_reg;
    rdata_next = rdata_reg;
    if (avs_read && !ack_reg) begin
      case (avs_address)
        EWT_CTRL_OFS:    rdata_next = {24'h0, 1'b0, ctrl_reg[6:0]};
        EWT_COUNT_OFS:   rdata_next = {24'h0, count_reg};
        EWT_COMPARE_OFS: rdata_next = {24'h0, cmp_buf_reg};
        EWT_FLAGS_OFS:   rdata_next = {30'h0, cmf_reg, ovf_reg};
        EWT_PORT_OFS:    rdata_next = {31'h0, dir_reg};
        default:         rdata_next = EWT_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata = rdata_reg;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Single-cycle enable drives counting, flag sets and compare events; the force strobe acts without it
  ewt_prescaler u_presc (
    .clk    (clk),
    .resetn (resetn),
    .cs     (ctrl.cs),
    .tick   (tick)
  );

  // ----------------------------------------------------------------
  // Counter, compare buffer and flags
  // ----------------------------------------------------------------
  // Match blocked on the tick after a counter write
  assign evt.match     = (count_reg == cmp_reg) && !block_reg;
  assign evt.up        = !down_reg;
  assign evt.at_top    = (count_reg == EWT_MAX);
  assign evt.at_bottom = (count_reg == EWT_BOTTOM);

  // Force only acts outside PWM modes; ignored otherwise
  assign force_cmp = wr_take && avs_address == EWT_CTRL_OFS &&
                     avs_byteenable[0] &&
                     avs_writedata[EWT_FOC_BIT] && !pwm_mode;

  // Leaving MAX, or an up match missed, still ends up-matched
  assign sym_leave  = evt.at_bottom && (cmp_buf_reg != cmp_reg) && cmp_is_max;
  assign sym_missed = evt.at_top && !down_reg && !cmp_is_max;
  assign sym_fix    = (ctrl.mode == EWT_PHASE) && (sym_leave || sym_missed);

  // Flag events, so a same-cycle clear never beats a repeated set
  assign ovf_set = tick && ((ctrl.mode == EWT_PHASE) ?
                            (down_reg && count_reg == 8'h01) :
                            (count_reg == EWT_MAX));
  assign cmf_set = tick && evt.match;

  always_comb begin
    ctrl_next    = ctrl_reg;
    count_next   = count_reg;
    cmp_buf_next = cmp_buf_reg;
    cmp_next     = cmp_reg;
    down_next    = down_reg;
    ovf_next     = ovf_reg;
    cmf_next     = cmf_reg;
    dir_next     = dir_reg;
    block_next   = block_reg;

    if (tick) begin
      block_next = 1'b0;
      case (ctrl.mode)
        EWT_PHASE: begin
          // Dual slope; turn at MAX; 510 ticks
          if (!down_reg) begin
            if (count_reg == EWT_MAX) begin
              down_next  = 1'b1;
              count_next = count_reg - 8'h01;
            end else begin
              count_next = count_reg + 8'h01;
            end
          end else if (count_reg == EWT_BOTTOM) begin
            down_next  = 1'b0;
            count_next = count_reg + 8'h01;
          end else begin
            count_next = count_reg - 8'h01;
          end
          if (down_reg && count_reg == 8'h01) begin
            ovf_next = 1'b1;
          end
          if (count_reg == EWT_MAX) begin
            cmp_next = cmp_buf_reg;
          end
        end
        EWT_FAST: begin
          down_next  = 1'b0;
          count_next = count_reg + 8'h01;
          // Overflow at MAX, compare load at BOTTOM
          if (count_reg == EWT_MAX) begin
            ovf_next = 1'b1;
            cmp_next = cmp_buf_reg;
          end
        end
        default: begin
          down_next  = 1'b0;
          count_next = (count_reg == top_val && ctrl.mode == EWT_CTC) ?
                       EWT_BOTTOM : count_reg + 8'h01;
          if (count_reg == EWT_MAX) begin
            ovf_next = 1'b1;
          end
        end
      endcase
      if (evt.match) begin
        cmf_next = 1'b1;
      end
    end

    // Immediate compare update in non-PWM modes
    if (!pwm_mode) begin
      cmp_next = cmp_buf_next;
    end

    if (wr_take && avs_byteenable[0]) begin
      case (avs_address)
        EWT_CTRL_OFS:    ctrl_next = {1'b0, avs_writedata[6:0]};
        EWT_COUNT_OFS: begin
          count_next = merge(count_reg, avs_writedata, avs_byteenable);
          block_next = 1'b1;
        end
        EWT_COMPARE_OFS: begin
          cmp_buf_next = avs_writedata[7:0];
          if (!pwm_mode) begin
            cmp_next = avs_writedata[7:0];
          end
        end
        // Write one clears; a same-cycle set wins
        EWT_FLAGS_OFS: begin
          if (avs_writedata[EWT_OVF_BIT] && !ovf_set) begin
            ovf_next = 1'b0;
          end
          if (avs_writedata[EWT_CMF_BIT] && !cmf_set) begin
            cmf_next = 1'b0;
          end
        end
        EWT_PORT_OFS:    dir_next = avs_writedata[EWT_DIR_BIT];
        default:         ctrl_next = ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg    <= EWT_CTRL_RST;
      count_reg   <= EWT_COUNT_RST;
      cmp_buf_reg <= EWT_CMP_RST;
      cmp_reg     <= EWT_CMP_RST;
      down_reg    <= 1'b0;
      ovf_reg     <= 1'b0;
      cmf_reg     <= 1'b0;
      dir_reg     <= 1'b0;
      block_reg   <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      count_reg   <= count_next;
      cmp_buf_reg <= cmp_buf_next;
      cmp_reg     <= cmp_next;
      down_reg    <= down_next;
      ovf_reg     <= ovf_next;
      cmf_reg     <= cmf_next;
      dir_reg     <= dir_next;
      block_reg   <= block_next;
    end
  end

  // ----------------------------------------------------------------
  // Waveform and pin
  // ----------------------------------------------------------------
  ewt_waveform u_wave (
    .clk        (clk),
    .resetn     (resetn),
    .ctrl       (ctrl),
    .tick       (tick),
    .evt        (evt),
    .force_cmp  (force_cmp),
    .cmp_is_max (cmp_is_max),
    .sym_fix    (sym_fix),
    .wave       (wave)
  );

  // Override when compare mode nonzero, driver only with direction set
  assign port_override        = |ctrl.com;
  assign waveform_output      = wave;
  assign waveform_output_oe_n = !(port_override && dir_reg);
  assign overflow_flag        = ovf_reg;
  assign compare_match_flag   = cmf_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_phase_turn_max: assert property (
    @(posedge clk) disable iff (!resetn)
    (tick && ctrl.mode == EWT_PHASE && !down_reg &&
     count_reg == EWT_MAX && !wr_take) |=> down_reg)
    else $error("phase mode did not turn at MAX");

  a_phase_ovf_bottom: assert property (
    @(posedge clk) disable iff (!resetn)
    (tick && ctrl.mode == EWT_PHASE && down_reg && count_reg == 8'h01)
    |=> ovf_reg)
    else $error("overflow not set at BOTTOM");

  a_fast_ovf_max: assert property (
    @(posedge clk) disable iff (!resetn)
    (tick && ctrl.mode == EWT_FAST && count_reg == EWT_MAX) |=> ovf_reg)
    else $error("overflow not set at MAX");

  a_force_reads_zero: assert property (
    @(posedge clk) disable iff (!resetn)
    !ctrl_reg[EWT_FOC_BIT])
    else $error("strobe bit stored");

  a_pin_enable: assert property (
    @(posedge clk) disable iff (!resetn)
    (ctrl.com == 2'h0) |-> waveform_output_oe_n)
    else $error("pin driven while disconnected");

  a_write_blocks: assert property (
    @(posedge clk) disable iff (!resetn)
    (wr_take && avs_address == EWT_COUNT_OFS && avs_byteenable[0])
    |=> !evt.match)
    else $error("match not blocked after counter write");

  a_block_keeps_flag: assert property (
    @(posedge clk) disable iff (!resetn)
    (tick && block_reg && !wr_take) |=> (cmf_reg == $past(cmf_reg)))
    else $error("blocked tick changed the match flag");

  a_ctc_clear: assert property (
    @(posedge clk) disable iff (!resetn)
    (tick && ctrl.mode == EWT_CTC && count_reg == cmp_reg && !wr_take)
    |=> count_reg == EWT_BOTTOM)
    else $error("clear-on-match did not clear");

  a_stop_holds: assert property (
    @(posedge clk) disable iff (!resetn)
    (ctrl.cs == 3'h0 && !wr_take) |=> $stable(count_reg))
    else $error("stopped timer counted");

endmodule

// File: verification/ewt_timer_bench.sv
// Self-checking bench for the eight-bit waveform timer
`timescale 1ns/1ps
module ewt_timer_bench import ewt_pkg::*;;

  localparam int LIMIT = 60000;

  logic        clk;
  logic        resetn;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        waveform_output;
  logic        waveform_output_oe_n;
  logic        port_override;
  logic        overflow_flag;
  logic        compare_match_flag;
  int          n_mismatch;
  int          checks;
  int          cycle;

  // Prescaler divisors per clock select code
  int divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  // Flag period rows: mode, flag index, period in ticks
  int per [4][3] = '{'{0, 0, 256}, '{1, 0, 510}, '{2, 1, 32}, '{3, 0, 256}};
  // Duty rows: mode, compare mode, compare, window, high cycles
  int pw [11][5] = '{
    '{3, 2, 8'h3f, 256, 64},  '{3, 3, 8'h3f, 256, 192},
    '{3, 2, 8'hff, 256, 256}, '{3, 3, 8'hff, 256, 0},
    '{3, 1, 8'h10, 512, 256}, '{1, 2, 8'h40, 510, 128},
    '{1, 3, 8'h40, 510, 382}, '{1, 2, 8'h00, 510, 0},
    '{1, 2, 8'hff, 510, 510}, '{1, 3, 8'h00, 510, 510},
    '{2, 1, 8'h1f, 64, 32}};
  logic [1:0] fc [5] = '{2'h1, 2'h1, 2'h3, 2'h3, 2'h2};
  logic       fo [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  ewt_timer dut_u (
    .clk                  (clk),
    .resetn               (resetn),
    .avs_address          (avs_address),
    .avs_read             (avs_read),
    .avs_write            (avs_write),
    .avs_writedata        (avs_writedata),
    .avs_byteenable       (avs_byteenable),
    .avs_readdata         (avs_readdata),
    .avs_waitrequest      (avs_waitrequest),
    .waveform_output      (waveform_output),
    .waveform_output_oe_n (waveform_output_oe_n),
    .port_override        (port_override),
    .overflow_flag        (overflow_flag),
    .compare_match_flag   (compare_match_flag)
  );

  // ----------------------------------------------------------------
  // Clock, time-zero values and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    resetn         = 1'b0;
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'h0;
    n_mismatch     = 0;
    checks         = 0;
    cycle          = 0;
  end

  always @(posedge clk) begin
    cycle <= cycle + 1;
    if (cycle == LIMIT) begin
      n_mismatch++;
      $display("BAD timeout expected %0d seen %0d", LIMIT, cycle);
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Outputs read right after an edge still show pre-edge values
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d,
                           input logic [3:0] be);
    avs_address    <= a;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read    <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  // Edge stamp of a flag rise, then clear both flags
  task automatic flag_stamp(input int b, output int st);
    while ((b == 0 ? overflow_flag : compare_match_flag) !== 1'b1) begin
      @(posedge clk);
    end
    st = cycle;
    bus_write(EWT_FLAGS_OFS, 8'h03, 4'h1);
  endtask

  function automatic logic [7:0] ctl(input logic [1:0] m,
                                     input logic [1:0] com,
                                     input logic [2:0] cs);
    return {1'b0, m[0], com, m[1], cs};
  endfunction

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [31:0] d0;
    int          st [3];
    int          hi;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // Five registers plus one unmapped offset, all zero
    for (int i = 0; i < 6; i++) begin
      bus_read(8'(EWT_CTRL_OFS + 4 * i), d);
      check("reset read", d, 32'h0);
    end
    check("reset oe_n", waveform_output_oe_n, 32'h1);
    check("reset override", port_override, 32'h0);
    bus_write(EWT_CTRL_OFS, 8'h12, 4'h0);
    bus_read(EWT_CTRL_OFS, d);
    check("masked write", d, 32'h0);
    $display("test reset done");

    bus_write(EWT_COUNT_OFS, 8'h37, 4'h1);
    bus_write(EWT_PORT_OFS, 8'h01, 4'h1);
    for (int i = 0; i < 5; i++) begin
      // Strobe acts with the compare mode already stored
      bus_write(EWT_CTRL_OFS, ctl(EWT_NORMAL, fc[i], 3'h0), 4'h1);
      bus_write(EWT_CTRL_OFS, 8'h80 | ctl(EWT_NORMAL, fc[i], 3'h0), 4'h1);
      repeat (3) @(posedge clk);
      check("forced output", waveform_output, fo[i]);
      bus_read(EWT_CTRL_OFS, d);
      check("control read", d, ctl(EWT_NORMAL, fc[i], 3'h0));
    end
    check("forced flag", compare_match_flag, 32'h0);
    bus_read(EWT_COUNT_OFS, d);
    check("count kept", d, 32'h37);
    check("override on", port_override, 32'h1);
    check("driver on", waveform_output_oe_n, 32'h0);
    bus_write(EWT_PORT_OFS, 8'h00, 4'h1);
    check("driver off", waveform_output_oe_n, 32'h1);
    $display("test force done");

    // Tick count over exactly eight divider periods
    for (int c = 0; c < 8; c++) begin
      bus_write(EWT_CTRL_OFS, ctl(EWT_NORMAL, 2'h0, 3'(c)), 4'h1);
      bus_read(EWT_COUNT_OFS, d0);
      repeat (c == 0 ? 30 : 8 * divs[c] - 3) @(posedge clk);
      bus_read(EWT_COUNT_OFS, d);
      check("ticks", {24'h0, d[7:0] - d0[7:0]}, c == 0 ? 0 : 8);
    end
    $display("test prescaler done");

    bus_write(EWT_CTRL_OFS, 8'h00, 4'h1);
    bus_write(EWT_COMPARE_OFS, 8'h05, 4'h1);
    // Counter set while stopped: the first tick lands on the match
    bus_write(EWT_COUNT_OFS, 8'h05, 4'h1);
    bus_write(EWT_FLAGS_OFS, 8'h03, 4'h1);
    bus_write(EWT_CTRL_OFS, ctl(EWT_NORMAL, 2'h0, 3'h1), 4'h1);
    repeat (3) @(posedge clk);
    check("blocked match", compare_match_flag, 32'h0);
    repeat (260) @(posedge clk);
    check("later match", compare_match_flag, 32'h1);
    $display("test count write done");

    for (int i = 0; i < 4; i++) begin
      bus_write(EWT_COMPARE_OFS, 8'h1f, 4'h1);
      bus_write(EWT_CTRL_OFS, ctl(2'(per[i][0]), 2'h0, 3'h1), 4'h1);
      bus_write(EWT_FLAGS_OFS, 8'h03, 4'h1);
      for (int k = 0; k < 3; k++) flag_stamp(per[i][1], st[k]);
      check("flag period", st[2] - st[1], per[i][2]);
    end
    $display("test periods done");

    // Settle past two periods so buffered compare has landed
    for (int i = 0; i < 11; i++) begin
      bus_write(EWT_COMPARE_OFS, 8'(pw[i][2]), 4'h1);
      bus_write(EWT_CTRL_OFS, ctl(2'(pw[i][0]), 2'(pw[i][1]), 3'h1), 4'h1);
      repeat (1100) @(posedge clk);
      hi = 0;
      repeat (pw[i][3]) begin
        @(posedge clk);
        if (waveform_output === 1'b1) hi++;
      end
      check("high cycles", hi, pw[i][4]);
    end
    $display("test waveforms done");
    report_and_stop();
  end

endmodule
